// ---- bench/rx_address_filter_tb.sv ----
`timescale 1ns/100ps
module rx_address_filter_tb;
  logic clock, rst_n, hsel, hwrite, hready, hresp;
  logic rx_active, rx_bit_valid, rx_bit, mode_load, frame_done;
  logic next_own, next_polled, addr_done, accept, irq, i0, i1;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] mode, fcs_mode;
  logic [63:0] m;
  logic [5:0] hx;
  rxf_pkg::rxf_frame_st_t frame_st;
  int fails, checks, cyc, n_acc;
  localparam logic [47:0] NODE = 48'h554433221102;
  localparam logic [47:0] LOG = 48'h123456789A01;
  localparam logic [47:0] BC = 48'hFFFFFFFFFFFF;
  rxf_filter u_rxf_filter (.i_clock(clock), .i_rst_n(rst_n),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .i_rx_active(rx_active),
    .i_rx_bit_valid(rx_bit_valid), .i_rx_bit(rx_bit),
    .i_init_mode_load(mode_load), .i_init_mode(mode),
    .i_frame_done(frame_done), .i_frame_st(frame_st),
    .i_next_own(next_own), .i_next_polled(next_polled),
    .o_addr_done(addr_done), .o_accept(accept),
    .o_tx_fcs_mode(fcs_mode), .o_irq(irq));
  rxf_net_model u_rxf_net_model (.i_clock(clock),
    .o_rx_active(rx_active), .o_rx_bit_valid(rx_bit_valid),
    .o_rx_bit(rx_bit));
  always #5 clock = ~clock;
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= rxf_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic frame(input logic [47:0] da, input logic exp);
    int n;
    u_rxf_net_model.send(da);
    n = 0;
    while (addr_done !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    check({31'h0, addr_done}, 32'h1);
    check({31'h0, accept}, {31'h0, exp});
    if (exp) n_acc++;
    u_rxf_net_model.idle();
  endtask
  task automatic setmode(input logic dis, input logic prom);
    bus(1'b1, rxf_pkg::ADDR_MODE, (32'(dis) << rxf_pkg::MODE_DIS_BCAST) |
        (32'(prom) << rxf_pkg::MODE_PROM));
  endtask
  task automatic desc(input logic [4:0] st, input logic own,
                      input logic pol, input logic [7:0] exp);
    @(posedge clock);
    frame_st <= rxf_pkg::rxf_frame_st_t'(st);
    next_own <= own;
    next_polled <= pol;
    frame_done <= 1'b1;
    @(posedge clock);
    frame_done <= 1'b0;
    bus(1'b0, rxf_pkg::ADDR_DESC_ST, 32'h0);
    check({24'h0, rd[7:0]}, {24'h0, exp});
  endtask
  // hash index from the same serial crc the hardware runs
  function automatic logic [5:0] hidx(input logic [47:0] da);
    logic [31:0] c;
    c = rxf_pkg::CRC_INIT;
    for (int i = 0; i < 48; i++)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ da[i]) ? rxf_pkg::CRC_POLY : 32'h0);
    return c[31:26];
  endfunction
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0; rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0;
    htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0; mode_load = 1'b0;
    mode = 16'h0; frame_done = 1'b0; frame_st = '0; next_own = 1'b1;
    next_polled = 1'b1; fails = 0; checks = 0; cyc = 0; n_acc = 0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    bus(1'b0, rxf_pkg::ADDR_MODE, 32'h0);
    check(rd, {16'h0, rxf_pkg::MODE_RESET});
    check({30'h0, accept, irq}, 32'h0);
    check({31'h0, hresp}, 32'h0);
    @(posedge clock);
    mode_load <= 1'b1;
    mode <= 16'h0008;
    @(posedge clock);
    mode_load <= 1'b0;
    @(posedge clock);
    check({16'h0, fcs_mode}, 32'h8);
    // conventional 02:11:22:33:44:55, first byte low, bit 0 clear
    bus(1'b1, rxf_pkg::ADDR_NODE_LO, NODE[31:0]);
    bus(1'b1, rxf_pkg::ADDR_NODE_HI, {16'h0, NODE[47:32]});
    setmode(1'b0, 1'b0);
    frame(NODE, 1'b1);
    frame(NODE ^ 48'h000000000100, 1'b0);
    frame(LOG, 1'b0);
    hx = hidx(LOG);
    m = 64'h1 << hx;
    bus(1'b1, rxf_pkg::ADDR_HASH_LO, m[31:0]);
    bus(1'b1, rxf_pkg::ADDR_HASH_HI, m[63:32]);
    frame(LOG, 1'b1);
    bus(1'b1, rxf_pkg::ADDR_HASH_LO, ~m[31:0]);
    bus(1'b1, rxf_pkg::ADDR_HASH_HI, ~m[63:32]);
    frame(LOG, 1'b0);
    bus(1'b1, rxf_pkg::ADDR_HASH_LO, 32'h0);
    bus(1'b1, rxf_pkg::ADDR_HASH_HI, 32'h0);
    for (int k = 0; k < 4; k++) begin
      setmode(k[1], k[0]);
      frame(BC, !k[1] || k[0]);
    end
    frame(NODE ^ 48'h000000000100, 1'b1);
    setmode(1'b0, 1'b0);
    bus(1'b1, rxf_pkg::ADDR_BUF_ADDR, 32'hFFABCDEF);
    bus(1'b0, rxf_pkg::ADDR_BUF_ADDR, 32'h0);
    check({8'h0, rd[23:0]}, 32'h00ABCDEF);
    bus(1'b0, 8'h3C, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, rxf_pkg::ADDR_DESC_ST, 32'h80);
    desc(5'h05, 1'b1, 1'b1, 8'h49);
    bus(1'b1, rxf_pkg::ADDR_DESC_ST, 32'h80);
    desc(5'h00, 1'b0, 1'b1, 8'h44);
    bus(1'b1, rxf_pkg::ADDR_DESC_ST, 32'h80);
    desc(5'h11, 1'b1, 1'b1, 8'h61);
    bus(1'b1, rxf_pkg::ADDR_DESC_ST, 32'h80);
    desc(5'h08, 1'b1, 1'b1, 8'h50);
    desc(5'h05, 1'b1, 1'b1, 8'h50);
    bus(1'b0, rxf_pkg::ADDR_ACCEPT, 32'h0);
    check(rd, n_acc);
    bus(1'b0, rxf_pkg::ADDR_IRQ_ST, 32'h0);
    check({29'h0, rd[2:0]}, 32'h7);
    bus(1'b1, rxf_pkg::ADDR_IRQ_MASK, 32'h0);
    @(posedge clock);
    i0 = irq;
    bus(1'b1, rxf_pkg::ADDR_IRQ_MASK, 32'h7);
    @(posedge clock);
    i1 = irq;
    check({31'h0, i0}, 32'h0);
    check({31'h0, i1}, 32'h1);
    bus(1'b1, rxf_pkg::ADDR_IRQ_ST, 32'h7);
    bus(1'b0, rxf_pkg::ADDR_IRQ_ST, 32'h0);
    check({29'h0, rd[2:0]}, 32'h0);
    check({31'h0, irq}, 32'h0);
    give_verdict();
  end
endmodule

// ---- bench/rxf_net_model.sv ----
`timescale 1ns/100ps
// ---------------------------------------------------------------
// network side: serial destination address
// ---------------------------------------------------------------
module rxf_net_model (
  // clock
  input wire logic i_clock,
  // decoded bit stream
  output logic o_rx_active,
  output logic o_rx_bit_valid,
  output logic o_rx_bit
);
  initial begin
    o_rx_active = 1'b0;
    o_rx_bit_valid = 1'b0;
    o_rx_bit = 1'b0;
  end
  // address bit n goes out n-th, so node bit 0 leads
  task automatic send(input logic [47:0] da);
    @(posedge i_clock);
    o_rx_active <= 1'b1;
    for (int i = 0; i < 48; i++) begin
      @(posedge i_clock);
      o_rx_bit_valid <= 1'b1;
      o_rx_bit <= da[i];
    end
    @(posedge i_clock);
    // released line shows the inverse so a stale bit never helps
    o_rx_bit_valid <= 1'b0;
    o_rx_bit <= ~da[47];
  endtask
  // the frame stays open past the address so the filter can decide;
  // dropping activity only after the decision, then one idle cycle
  task automatic idle();
    @(posedge i_clock);
    o_rx_active <= 1'b0;
    @(posedge i_clock);
  endtask
endmodule

// ---- core/rxf_filter.sv ----
`timescale 1ns/100ps
module rxf_filter #(
  parameter int ADDR_W = 48
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // receive bit stream from the decoder, wire order
  input wire logic i_rx_active,
  input wire logic i_rx_bit_valid,
  input wire logic i_rx_bit,
  // init block mode word load
  input wire logic i_init_mode_load,
  input wire logic [15:0] i_init_mode,
  // end of frame status from the receive path
  input wire logic i_frame_done,
  input wire rxf_pkg::rxf_frame_st_t i_frame_st,
  input wire logic i_next_own,
  input wire logic i_next_polled,
  // filter outcome, mode word and interrupt
  output logic o_addr_done,
  output logic o_accept,
  output logic [15:0] o_tx_fcs_mode,
  output logic o_irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [47:0] node_q, node_d;
  logic [63:0] hash_q, hash_d;
  logic [15:0] mode_q, mode_d;
  logic [7:0] desc_st_q, desc_st_d;
  logic [23:0] buf_q, buf_d;
  logic [2:0] irq_st_q, irq_st_d;
  logic [2:0] irq_mask_q, irq_mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] acc_cnt_q, acc_cnt_d;

  logic [47:0] da_q, da_d;
  logic [5:0] cnt_q, cnt_d;
  logic [31:0] crc_q, crc_d;
  logic done_q, done_d;
  logic acc_q, acc_d;
  logic irq_q, irq_d;

  rxf_pkg::rxf_bus_req_t req_q, req_d;

  // ---------------------------------------------------------------
  // address decode function
  // ---------------------------------------------------------------
  function automatic logic [31:0] reg_read(input logic [7:0] a,
      input logic [47:0] n, input logic [63:0] h, input logic [15:0] m,
      input logic [7:0] s, input logic [23:0] b, input logic [2:0] st,
      input logic [2:0] mk, input logic [15:0] ac);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      rxf_pkg::ADDR_NODE_LO: r = n[31:0];
      rxf_pkg::ADDR_NODE_HI: r = {16'h0000, n[47:32]};
      rxf_pkg::ADDR_HASH_LO: r = h[31:0];
      rxf_pkg::ADDR_HASH_HI: r = h[63:32];
      rxf_pkg::ADDR_MODE: r = {16'h0000, m};
      rxf_pkg::ADDR_DESC_ST: r = {24'h000000, s};
      rxf_pkg::ADDR_BUF_ADDR: r = {8'h00, b};
      rxf_pkg::ADDR_IRQ_ST: r = {29'h00000000, st};
      rxf_pkg::ADDR_IRQ_MASK: r = {29'h00000000, mk};
      rxf_pkg::ADDR_ACCEPT: r = {16'h0000, ac};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // address filter
  // ---------------------------------------------------------------
  logic is_logical, is_bcast, phys_hit, hash_hit, prom, dis_bc, fb;
  logic [5:0] hidx;
  always_comb begin
    prom = mode_q[rxf_pkg::MODE_PROM];
    dis_bc = mode_q[rxf_pkg::MODE_DIS_BCAST];
    fb = crc_q[31] ^ i_rx_bit;
    crc_d = crc_q;
    da_d = da_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    acc_d = acc_q;
    is_logical = da_q[0];
    is_bcast = &da_q;
    phys_hit = !is_logical && (da_q == node_q);
    // crc register is msb first, so its top six bits form the index
    hidx = crc_q[31:26];
    hash_hit = hash_q[hidx];
    if (!i_rx_active) begin
      cnt_d = 6'd0;
      crc_d = rxf_pkg::CRC_INIT;
    end else if (i_rx_bit_valid && cnt_q < 6'(rxf_pkg::ADDR_BITS)) begin
      // wire order fills bit 0 first, matching node address layout
      da_d = {i_rx_bit, da_q[47:1]};
      crc_d = {crc_q[30:0], 1'b0} ^ (fb ? rxf_pkg::CRC_POLY : 32'h0);
      cnt_d = cnt_q + 6'd1;
    end else if (cnt_q == 6'(rxf_pkg::ADDR_BITS)) begin
      cnt_d = cnt_q + 6'd1;
      done_d = 1'b1;
      if (is_bcast) begin
        acc_d = !dis_bc || prom;
      end else if (is_logical) begin
        acc_d = hash_hit || prom;
      end else begin
        acc_d = phys_hit || prom;
      end
    end
  end

  // ---------------------------------------------------------------
  // descriptor status and registers
  // ---------------------------------------------------------------
  logic wr_en;
  logic [2:0] ev;
  always_comb begin
    req_d = req_q;
    node_d = node_q;
    hash_d = hash_q;
    mode_d = mode_q;
    desc_st_d = desc_st_q;
    buf_d = buf_q;
    irq_mask_d = irq_mask_q;
    acc_cnt_d = acc_cnt_q;
    rdata_d = rdata_q;
    ev = 3'b000;
    wr_en = req_q.valid && req_q.write;
    if (wr_en) begin
      unique case (req_q.addr[7:0])
        // loader keeps node bit 0 clear; stored as written
        rxf_pkg::ADDR_NODE_LO: node_d[31:0] = i_hwdata;
        rxf_pkg::ADDR_NODE_HI: node_d[47:32] = i_hwdata[15:0];
        rxf_pkg::ADDR_HASH_LO: hash_d[31:0] = i_hwdata;
        rxf_pkg::ADDR_HASH_HI: hash_d[63:32] = i_hwdata;
        rxf_pkg::ADDR_MODE: mode_d = i_hwdata[15:0];
        rxf_pkg::ADDR_DESC_ST: desc_st_d[rxf_pkg::ST_OWN] =
            i_hwdata[rxf_pkg::ST_OWN];
        rxf_pkg::ADDR_BUF_ADDR: buf_d = i_hwdata[23:0];
        rxf_pkg::ADDR_IRQ_MASK: irq_mask_d = i_hwdata[2:0];
        default: ;
      endcase
    end
    if (i_init_mode_load) begin
      mode_d = i_init_mode;
    end
    if (done_q) begin
      ev[rxf_pkg::IRQ_ACCEPT] = acc_q;
      ev[rxf_pkg::IRQ_REJECT] = !acc_q;
      if (acc_q) begin
        acc_cnt_d = acc_cnt_q + 16'd1;
      end
    end
    if (i_frame_done && desc_st_q[rxf_pkg::ST_OWN]) begin
      ev[rxf_pkg::IRQ_DESC] = 1'b1;
      desc_st_d[rxf_pkg::ST_ENP] = i_frame_st.end_of_frame_flag;
      desc_st_d[rxf_pkg::ST_OVERFLOW_FLAG] = i_frame_st.overflow_flag;
      desc_st_d[rxf_pkg::ST_FRAMING_ERROR_FLAG] = i_frame_st.framing_error_flag;
      desc_st_d[rxf_pkg::ST_CRC] = i_frame_st.crc;
      desc_st_d[rxf_pkg::ST_BUFFER_ERROR_FLAG] = i_frame_st.buffer_error_flag ||
          (!i_frame_st.end_of_frame_flag && (!i_next_own || !i_next_polled));
      desc_st_d[rxf_pkg::ST_ERR] = i_frame_st.framing_error_flag || i_frame_st.overflow_flag ||
          i_frame_st.crc || desc_st_d[rxf_pkg::ST_BUFFER_ERROR_FLAG];
      desc_st_d[rxf_pkg::ST_OWN] = 1'b0;
    end
    // set wins over a write-one-to-clear in the same cycle
    irq_st_d = (irq_st_q & ~((wr_en &&
        req_q.addr[7:0] == rxf_pkg::ADDR_IRQ_ST) ? i_hwdata[2:0] : 3'b000))
        | ev;
    irq_d = |(irq_st_d & irq_mask_d);
    req_d.valid = i_hsel && i_hready && i_htrans == rxf_pkg::HTRANS_NONSEQ;
    req_d.addr = i_haddr;
    req_d.write = i_hwrite;
    if (req_d.valid && !i_hwrite) begin
      rdata_d = reg_read(i_haddr[7:0], node_d, hash_d, mode_d, desc_st_d,
          buf_d, irq_st_d, irq_mask_d, acc_cnt_d);
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      node_q <= '0;
      hash_q <= '0;
      mode_q <= rxf_pkg::MODE_RESET;
      desc_st_q <= '0;
      buf_q <= '0;
      irq_st_q <= '0;
      irq_mask_q <= '0;
      rdata_q <= '0;
      acc_cnt_q <= '0;
      da_q <= '0;
      cnt_q <= '0;
      crc_q <= rxf_pkg::CRC_INIT;
      done_q <= 1'b0;
      acc_q <= 1'b0;
      irq_q <= 1'b0;
      req_q <= '0;
    end else begin
      node_q <= node_d;
      hash_q <= hash_d;
      mode_q <= mode_d;
      desc_st_q <= desc_st_d;
      buf_q <= buf_d;
      irq_st_q <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      rdata_q <= rdata_d;
      acc_cnt_q <= acc_cnt_d;
      da_q <= da_d;
      cnt_q <= cnt_d;
      crc_q <= crc_d;
      done_q <= done_d;
      acc_q <= acc_d;
      irq_q <= irq_d;
      req_q <= req_d;
    end
  end

  assign o_hrdata = rdata_q;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_addr_done = done_q;
  assign o_accept = acc_q;
  assign o_tx_fcs_mode = mode_q;
  assign o_irq = irq_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_bcast_disabled: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    done_d && is_bcast && dis_bc && !prom |=> !o_accept)
    else $error("disabled broadcast accepted");
  a_bcast_open: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    done_d && is_bcast && (!dis_bc || prom) |=> o_accept)
    else $error("broadcast rejected");
  a_hash_empty: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    done_d && is_logical && !is_bcast && hash_q == 64'h0 && !prom
    |=> !o_accept)
    else $error("empty mask accepted logical");
  a_hash_pick: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    done_d && is_logical && !is_bcast && hash_q[crc_q[31:26]]
    |=> o_accept)
    else $error("hash hit rejected");
  a_phys_match: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    done_d && !da_q[0] && da_q == node_q |=> o_accept)
    else $error("physical match rejected");
  a_phys_miss: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    done_d && !da_q[0] && da_q != node_q && !prom |=> !o_accept)
    else $error("unmatched frame kept");
  a_err_sum: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(desc_st_q[rxf_pkg::ST_ERR]) |-> desc_st_q[rxf_pkg::ST_CRC] ||
    desc_st_q[rxf_pkg::ST_FRAMING_ERROR_FLAG] || desc_st_q[rxf_pkg::ST_OVERFLOW_FLAG] ||
    desc_st_q[rxf_pkg::ST_BUFFER_ERROR_FLAG])
    else $error("error summary without cause");
  a_own_drop: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_frame_done && desc_st_q[rxf_pkg::ST_OWN] |=>
    !desc_st_q[rxf_pkg::ST_OWN] && o_irq == |(irq_st_q & irq_mask_q))
    else $error("ownership not returned");
  a_mode_copy: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_init_mode_load |=> o_tx_fcs_mode == $past(i_init_mode))
    else $error("mode word not copied");
  c_bcast: cover property (@(posedge i_clock) done_q && &da_q && acc_q);
  c_hash: cover property (@(posedge i_clock) done_q && da_q[0] && acc_q);
  c_desc: cover property (@(posedge i_clock) i_frame_done && i_frame_st.crc);

endmodule

// ---- core/rxf_pkg.sv ----
package rxf_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_NODE_LO = 8'h00;
  localparam logic [7:0] ADDR_NODE_HI = 8'h04;
  localparam logic [7:0] ADDR_HASH_LO = 8'h08;
  localparam logic [7:0] ADDR_HASH_HI = 8'h0C;
  localparam logic [7:0] ADDR_MODE = 8'h10;
  localparam logic [7:0] ADDR_DESC_ST = 8'h14;
  localparam logic [7:0] ADDR_BUF_ADDR = 8'h18;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
  localparam logic [7:0] ADDR_ACCEPT = 8'h24;

  // ---------------------------------------------------------------
  // mode control register fields
  // ---------------------------------------------------------------
  localparam int MODE_DIS_BCAST = 14;
  localparam int MODE_PROM = 15;
  localparam int MODE_TX_FCS_DIS = 3;
  localparam logic [15:0] MODE_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // descriptor status byte (upper byte of rx_descriptor_word1)
  // ---------------------------------------------------------------
  localparam int ST_OWN = 7;
  localparam int ST_ERR = 6;
  localparam int ST_FRAMING_ERROR_FLAG = 5;
  localparam int ST_OVERFLOW_FLAG = 4;
  localparam int ST_CRC = 3;
  localparam int ST_BUFFER_ERROR_FLAG = 2;
  localparam int ST_ENP = 0;

  // interrupt status bits
  localparam int IRQ_ACCEPT = 0;
  localparam int IRQ_REJECT = 1;
  localparam int IRQ_DESC = 2;
  localparam int IRQ_W = 3;

  localparam int ADDR_BITS = 48;
  localparam int HASH_BITS = 6;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic write;
  } rxf_bus_req_t;

  // per-frame receive result presented at end of frame
  typedef struct packed {
    logic framing_error_flag;
    logic overflow_flag;
    logic crc;
    logic buffer_error_flag;
    logic end_of_frame_flag;
  } rxf_frame_st_t;

endpackage
